/* File: hdl/dispatch_map.svh */
// Notes on behaviour
// - Time request 0x21 answered with report 0x41.
// - Version request 0x1F answered with report 0x45.
// - Signal level request 0x27 answered with 0x47.
// - Fix request 0x37 answered with report 0x57.
// - Set time 0x2E acknowledged with report 0x4E.
// - Extended fix on 8E-20, 0x37, or auto.
// - Self-survey 8E-A6 answered with report 8F-A6.
// - Three stored sets: mobile, survey, timing.
// - Survey state picks the active set.
// - Survey state change switches set without command.
// - Only the active set accepts writes.
// - Dynamics and dimension limited per survey state.
// - Config subcode 0 alone queries, report answers.
// - Field 0xFF, or 0xFFFF for elevation, keeps stored value.
// - Dynamics default to land after reset.
// - Sea with auto dimension uses entered altitude.
// - Satellites below elevation mask excluded; default 0.1745.
// - Signal mask uses hysteresis for satellites both in use and locked.
// - Clear command mode 0x4B cold, 0x46 factory.
`ifndef DISPATCH_MAP_SVH
`define DISPATCH_MAP_SVH

// Request identifiers
`define ID_CLEAR_RST 8'h1e
`define ID_VER_REQ 8'h1f
`define ID_TIME_REQ 8'h21
`define ID_LEVEL_REQ 8'h27
`define ID_SET_TIME 8'h2e
`define ID_FIX_REQ 8'h37
`define ID_SUPER 8'h8e
`define ID_CONFIG 8'hbb

// Report identifiers
`define ID_TIME_RPT 8'h41
`define ID_VER_RPT 8'h45
`define ID_LEVEL_RPT 8'h47
`define ID_TIME_ACK 8'h4e
`define ID_FIX_RPT 8'h57
`define ID_SUPER_RPT 8'h8f

// Super packet subcodes
`define SUB_EXT_FIX 8'h20
`define SUB_SAVE 8'h26
`define SUB_SURVEY 8'ha6
`define SUB_NONE 8'h00
`define SUB_CFG_QUERY 8'h00

// Clear command modes
`define MODE_COLD 8'h4b
`define MODE_FACTORY 8'h46

// Payload lengths
`define LEN_NONE 8'h00
`define LEN_ONE 8'h01
`define LEN_SET_TIME 8'h06

// Field codes; dynamics and dimension encodings
`define KEEP8 8'hff
`define KEEP16 16'hffff
`define DYN_LAND 8'h01
`define DYN_SEA 8'h02
`define DYN_AIR 8'h03
`define DYN_STATIONARY 8'h04
`define DIM_AUTO 8'h00
`define DIM_2D 8'h03
`define DIM_3D 8'h04
`define DIM_SINGLE_SAT 8'h05
`define DIM_OVERDET 8'h07

// Reset values; elevation in units of 0.0001 rad, signal in 0.25 units
`define ELEV_DEFAULT 16'h06d1
`define LVL_DEFAULT 8'h10
`define LVL_HYST 8'h02

// Report queue and admission margin
`define FIFO_DEPTH 32
`define FIFO_MARGIN 3

`endif

/* File: hdl/dispatch_pkg.sv */
package dispatch_pkg;
  // Survey state as delivered by the survey engine
  typedef enum logic [1:0] {SURVEY_OFF, SURVEY_RUN, SURVEY_DONE} survey_e;
  // Stored configuration set selector
  typedef logic [1:0] set_t;
  // One stored configuration set
  typedef struct packed {
    logic [7:0] dyn;
    logic [7:0] dim;
    logic [15:0] elev;
    logic [7:0] lvl;
  } cfg_s;
  // One report queue entry: identifier then subcode
  typedef logic [15:0] rpt_t;
  // Dispatcher sequencing
  typedef enum logic {ST_IDLE, ST_SECOND} disp_e;
endpackage

/* File: hdl/dispatch_if.sv */
interface dispatch_if;
  import dispatch_pkg::*;
  logic push_valid;
  logic push_ready;
  rpt_t push_data;
  logic roomy;
  logic pop_valid;
  logic pop_ready;
  rpt_t pop_data;
  set_t rd_sel;
  set_t rd_sel_q;
  cfg_s rd_data;
  logic wr_en;
  set_t wr_sel;
  cfg_s wr_data;
  modport ctl (output push_valid, push_data, pop_ready, rd_sel, wr_en, wr_sel, wr_data,
               input push_ready, roomy, pop_valid, pop_data, rd_sel_q, rd_data);
  modport fifo (input push_valid, push_data, pop_ready,
                output push_ready, roomy, pop_valid, pop_data);
  modport bank (input rd_sel, wr_en, wr_sel, wr_data, output rd_sel_q, rd_data);
endinterface

/* File: hdl/report_fifo.sv */
`include "dispatch_map.svh"
module report_fifo
  import dispatch_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic nrst,
  dispatch_if.fifo q
);
  localparam int AW = $clog2(DEPTH);
  // Storage; output word sits in its own register stage
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic [WIDTH-1:0] out_q;
  logic out_v_q;
  wire do_push = q.push_valid && q.push_ready;
  wire load_out = (cnt_q != '0) && (!out_v_q || q.pop_ready);
  assign q.push_ready = cnt_q != (AW + 1)'(DEPTH);
  // Margin keeps one-cycle-stale admission safe
  assign q.roomy = cnt_q <= (AW + 1)'(DEPTH - `FIFO_MARGIN);
  assign q.pop_valid = out_v_q;
  assign q.pop_data = out_q;
  // Array write
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_q[wp_q] <= q.push_data;
    end
  end
  // Pointers, fill and output stage
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      out_v_q <= 1'b0;
      out_q <= '0;
    end else begin
      wp_q <= do_push ? wp_q + 1'b1 : wp_q;
      rp_q <= load_out ? rp_q + 1'b1 : rp_q;
      cnt_q <= cnt_q + (AW + 1)'(do_push) - (AW + 1)'(load_out);
      if (load_out) begin
        out_q <= mem_q[rp_q];
        out_v_q <= 1'b1;
      end else if (q.pop_ready) begin
        out_v_q <= 1'b0;
      end
    end
  end
endmodule

/* File: hdl/cfg_bank.sv */
`include "dispatch_map.svh"
module cfg_bank
  import dispatch_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  dispatch_if.bank b
);
  // Three stored sets: mobile, survey, timing
  cfg_s set_q [3];
  cfg_s rd_q;
  set_t sel_q;
  localparam cfg_s DEF = '{dyn: `DYN_LAND, dim: `DIM_AUTO, elev: `ELEV_DEFAULT,
                           lvl: `LVL_DEFAULT};
  assign b.rd_data = rd_q;
  assign b.rd_sel_q = sel_q;
  // Sets load defaults at reset; one write port
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < 3; i++) begin
        set_q[i] <= DEF;
      end
    end else if (b.wr_en && b.wr_sel != 2'h3) begin
      set_q[b.wr_sel] <= b.wr_data;
    end
  end
  // Registered read; reflects a write one cycle later
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_q <= DEF;
      sel_q <= '0;
    end else begin
      rd_q <= (b.rd_sel == 2'h3) ? DEF : set_q[b.rd_sel];
      sel_q <= b.rd_sel;
    end
  end
endmodule

/* File: hdl/cmd_dispatch.sv */
`include "dispatch_map.svh"
module cmd_dispatch
  import dispatch_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  // Received packet, one per handshake
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_id,
  input wire logic [7:0] cmd_sub,
  input wire logic [7:0] cmd_len,
  input wire logic [7:0] cmd_dyn,
  input wire logic [7:0] cmd_dim,
  input wire logic [15:0] cmd_elev,
  input wire logic [7:0] cmd_lvl,
  // Report identifiers toward the packet framer
  output logic rpt_valid,
  input wire logic rpt_ready,
  output logic [7:0] rpt_id,
  output logic [7:0] rpt_sub,
  // Automatic fix output
  input wire logic auto_en,
  input wire logic fix_tick,
  // Survey state and actions
  input wire logic [1:0] survey_state,
  output logic survey_cmd,
  output logic [7:0] survey_arg,
  output logic flash_save,
  output logic mem_clear,
  output logic flash_clear,
  output logic restart,
  output logic time_load,
  // Active configuration
  output logic [1:0] active_set,
  output logic [7:0] act_dyn,
  output logic [7:0] act_dim,
  output logic [15:0] act_elev,
  output logic [7:0] act_lvl,
  output logic alt_user,
  output logic cfg_written,
  output logic cfg_reject,
  // Per-satellite admission check
  input wire logic sv_check,
  input wire logic [15:0] sv_elev,
  input wire logic [7:0] sv_level,
  input wire logic sv_in_use,
  input wire logic sv_locked,
  output logic sv_use,
  output logic sv_use_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // Sub-blocks

  // Shared carrier to queue and set store
  dispatch_if u_if ();

  // Report queue keeps order and keeps reports whole
  report_fifo #(
    .WIDTH(16),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .q(u_if.fifo)
  );

  // Three configuration sets
  cfg_bank u_bank (
    .clk(clk),
    .nrst(nrst),
    .b(u_if.bank)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State

  disp_e st_q; // Dispatcher sequence
  disp_e st_d;
  logic ready_q; // Admission, from a flop
  logic auto_pend_q; // Automatic fix waiting for a queue slot
  logic survey_cmd_q;
  logic [7:0] survey_arg_q;
  logic flash_save_q;
  logic mem_clear_q;
  logic flash_clear_q;
  logic restart_q;
  logic time_load_q;
  logic cfg_written_q;
  logic cfg_reject_q;
  logic alt_user_q;
  logic sv_use_q;
  logic sv_use_v_q;
  set_t act_q;

  ////////////////////////////////////////////////////////////////////////////
  // Active set selection

  survey_e sstate;
  set_t act_now;
  assign sstate = survey_e'(survey_state);
  // Disabled maps to mobile, running to survey, done to timing
  assign act_now = (sstate == SURVEY_RUN) ? 2'h1 :
                   (sstate == SURVEY_DONE) ? 2'h2 : 2'h0;
  // Read port follows the survey state, no command needed
  assign u_if.rd_sel = act_now;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  wire take = cmd_valid && ready_q;
  wire no_data = cmd_len == `LEN_NONE;
  wire is_time = cmd_id == `ID_TIME_REQ && no_data;
  wire is_ver = cmd_id == `ID_VER_REQ && no_data;
  wire is_level = cmd_id == `ID_LEVEL_REQ && no_data;
  wire is_fix = cmd_id == `ID_FIX_REQ && no_data;
  wire is_settime = cmd_id == `ID_SET_TIME && cmd_len == `LEN_SET_TIME;
  wire is_super = cmd_id == `ID_SUPER && cmd_len != `LEN_NONE;
  wire is_ext_fix = is_super && cmd_sub == `SUB_EXT_FIX;
  wire is_survey = is_super && cmd_sub == `SUB_SURVEY;
  wire is_save = is_super && cmd_sub == `SUB_SAVE;
  wire is_cfg = cmd_id == `ID_CONFIG && cmd_sub == `SUB_CFG_QUERY;
  wire is_cfg_query = is_cfg && cmd_len == `LEN_ONE;
  wire is_cfg_set = is_cfg && cmd_len > `LEN_ONE;
  wire is_clear = cmd_id == `ID_CLEAR_RST && cmd_len == `LEN_ONE;
  wire is_cold = is_clear && cmd_sub == `MODE_COLD;
  wire is_factory = is_clear && cmd_sub == `MODE_FACTORY;

  // Report owed for the accepted packet; anything else yields none
  wire [7:0] r_id = is_time ? `ID_TIME_RPT :
                    is_ver ? `ID_VER_RPT :
                    is_level ? `ID_LEVEL_RPT :
                    is_fix ? `ID_FIX_RPT :
                    is_settime ? `ID_TIME_ACK :
                    is_cfg_query ? `ID_CONFIG :
                    `ID_SUPER_RPT;
  wire [7:0] r_sub = (is_ext_fix || is_survey || is_save) ? cmd_sub : `SUB_NONE;
  wire r_any = is_time || is_ver || is_level || is_fix || is_settime || is_cfg_query ||
               is_ext_fix || is_survey || is_save;
  wire cmd_push = take && r_any;
  wire second_push = st_q == ST_SECOND;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration write merge and limits

  cfg_s cur;
  cfg_s merged;
  assign cur = u_if.rd_data;
  // Keep codes leave the stored field untouched
  assign merged.dyn = (cmd_dyn == `KEEP8) ? cur.dyn : cmd_dyn;
  assign merged.dim = (cmd_dim == `KEEP8) ? cur.dim : cmd_dim;
  assign merged.elev = (cmd_elev == `KEEP16) ? cur.elev : cmd_elev;
  assign merged.lvl = (cmd_lvl == `KEEP8) ? cur.lvl : cmd_lvl;

  wire dyn_moving = merged.dyn == `DYN_LAND || merged.dyn == `DYN_SEA ||
                    merged.dyn == `DYN_AIR;
  wire dim_nav = merged.dim == `DIM_2D || merged.dim == `DIM_3D || merged.dim == `DIM_AUTO;
  wire dim_timing = merged.dim == `DIM_SINGLE_SAT || merged.dim == `DIM_OVERDET;
  // Mobile takes anything; survey and timing are fenced
  wire legal = (act_now == 2'h1) ? (dyn_moving && dim_nav) :
               (act_now == 2'h2) ? (merged.dyn == `DYN_STATIONARY && dim_timing) :
               1'b1;
  // Read data must belong to the set that is active now
  wire sel_fresh = u_if.rd_sel_q == act_now;
  wire cfg_ok = take && is_cfg_set && legal && sel_fresh;
  wire cfg_bad = take && is_cfg_set && !(legal && sel_fresh);

  // Writes only ever target the active set
  assign u_if.wr_en = cfg_ok;
  assign u_if.wr_sel = act_now;
  assign u_if.wr_data = merged;

  ////////////////////////////////////////////////////////////////////////////
  // Queue feed

  // Command reports first, automatic fix only into a free cycle
  wire auto_push = auto_pend_q && !cmd_push && !second_push && u_if.push_ready;
  assign u_if.push_valid = cmd_push || second_push || auto_push;
  assign u_if.push_data = second_push ? {`ID_SUPER_RPT, `SUB_EXT_FIX} :
                          auto_push ? {`ID_SUPER_RPT, `SUB_EXT_FIX} :
                          {r_id, r_sub};
  assign u_if.pop_ready = rpt_ready;

  // Extended fix follows the fix status report
  assign st_d = (take && is_fix) ? ST_SECOND : ST_IDLE;

  // Dispatcher sequence and admission
  // Stale by a cycle, so margin; pause after a write
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
      ready_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ready_q <= (st_d == ST_IDLE) && u_if.roomy && !cfg_ok;
    end
  end

  // Pending automatic fix; a new tick beats the clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      auto_pend_q <= 1'b0;
    end else if (fix_tick && auto_en) begin
      auto_pend_q <= 1'b1;
    end else if (auto_push) begin
      auto_pend_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Action pulses

  // One-cycle strobes to the receiver processor
  always_ff @(posedge clk) begin
    if (!nrst) begin
      survey_cmd_q <= 1'b0;
      flash_save_q <= 1'b0;
      mem_clear_q <= 1'b0;
      flash_clear_q <= 1'b0;
      restart_q <= 1'b0;
      time_load_q <= 1'b0;
      cfg_written_q <= 1'b0;
      cfg_reject_q <= 1'b0;
    end else begin
      survey_cmd_q <= take && is_survey;
      flash_save_q <= take && is_save;
      mem_clear_q <= take && (is_cold || is_factory);
      flash_clear_q <= take && is_factory;
      restart_q <= take && (is_cold || is_factory);
      time_load_q <= take && is_settime;
      cfg_written_q <= cfg_ok;
      cfg_reject_q <= cfg_bad;
    end
  end

  // Survey argument holds until the next survey command
  always_ff @(posedge clk) begin
    if (!nrst) begin
      survey_arg_q <= 8'h00;
    end else if (take && is_survey) begin
      survey_arg_q <= cmd_sub;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active configuration outputs

  // Sea with auto dimension falls back on the entered altitude
  always_ff @(posedge clk) begin
    if (!nrst) begin
      act_q <= 2'h0;
      alt_user_q <= 1'b0;
    end else begin
      act_q <= u_if.rd_sel_q;
      alt_user_q <= cur.dyn == `DYN_SEA && cur.dim == `DIM_AUTO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Satellite admission

  // Hysteresis: held satellites may dip, new ones must clear the band
  wire [8:0] lvl_lo = {1'b0, cur.lvl} - {1'b0, `LVL_HYST};
  wire [8:0] lvl_hi = {1'b0, cur.lvl} + {1'b0, `LVL_HYST};
  wire keep_lvl = lvl_lo[8] || ({1'b0, sv_level} >= lvl_lo);
  wire new_lvl = {1'b0, sv_level} >= lvl_hi;
  wire lvl_ok = (sv_in_use && sv_locked) ? keep_lvl : new_lvl;
  wire elev_ok = sv_elev >= cur.elev;

  // Verdict one cycle after the check strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sv_use_q <= 1'b0;
      sv_use_v_q <= 1'b0;
    end else begin
      sv_use_v_q <= sv_check;
      if (sv_check) begin
        sv_use_q <= elev_ok && lvl_ok;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port drive, all from flops

  assign cmd_ready = ready_q;
  assign rpt_valid = u_if.pop_valid;
  assign rpt_id = u_if.pop_data[15:8];
  assign rpt_sub = u_if.pop_data[7:0];
  assign survey_cmd = survey_cmd_q;
  assign survey_arg = survey_arg_q;
  assign flash_save = flash_save_q;
  assign mem_clear = mem_clear_q;
  assign flash_clear = flash_clear_q;
  assign restart = restart_q;
  assign time_load = time_load_q;
  assign active_set = act_q;
  assign act_dyn = cur.dyn;
  assign act_dim = cur.dim;
  assign act_elev = cur.elev;
  assign act_lvl = cur.lvl;
  assign alt_user = alt_user_q;
  assign cfg_written = cfg_written_q;
  assign cfg_reject = cfg_reject_q;
  assign sv_use = sv_use_q;
  assign sv_use_valid = sv_use_v_q;

endmodule

/* File: verif/cmd_dispatch_chk.sv */
`include "dispatch_map.svh"
module cmd_dispatch_chk
  import dispatch_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [7:0] cmd_id,
  input wire logic [7:0] cmd_sub,
  input wire logic [7:0] cmd_len,
  input wire logic [7:0] cmd_dyn,
  input wire logic [1:0] survey_state,
  input wire logic rpt_valid,
  input wire logic rpt_ready,
  input wire logic [7:0] rpt_id,
  input wire logic [7:0] rpt_sub,
  input wire logic time_load,
  input wire logic survey_cmd,
  input wire logic [7:0] survey_arg,
  input wire logic mem_clear,
  input wire logic flash_clear,
  input wire logic restart,
  input wire logic [1:0] active_set,
  input wire logic [7:0] act_dyn,
  input wire logic cfg_reject,
  input wire logic sv_check,
  input wire logic sv_use_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Packet consumed
  wire logic take = cmd_valid && cmd_ready;
  // One-byte packet, given id and byte
  sequence s_one(id, sub);
    take && cmd_id == id && cmd_sub == sub && cmd_len == `LEN_ONE;
  endsequence
  // Survey state steady over the select lag
  sequence s_steady;
    survey_state == $past(survey_state) && survey_state == $past(survey_state, 2);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_rpt_held: assert property (rpt_valid && !rpt_ready |=>
    rpt_valid && $stable(rpt_id) && $stable(rpt_sub)) else $error("report dropped early");
  a_time_ack: assert property (take && cmd_id == `ID_SET_TIME && cmd_len == `LEN_SET_TIME
    |=> time_load) else $error("time load missing");
  a_survey_cmd: assert property (s_one(`ID_SUPER, `SUB_SURVEY)
    |=> survey_cmd && survey_arg == `SUB_SURVEY) else $error("survey pulse missing");
  a_cold_start: assert property (s_one(`ID_CLEAR_RST, `MODE_COLD)
    |=> mem_clear && restart && !flash_clear) else $error("cold start wrong");
  a_factory_reset: assert property (s_one(`ID_CLEAR_RST, `MODE_FACTORY)
    |=> mem_clear && restart && flash_clear) else $error("factory reset wrong");
  a_bad_mode: assert property (take && cmd_id == `ID_CLEAR_RST && cmd_sub != `MODE_COLD
    && cmd_sub != `MODE_FACTORY |=> !restart && !mem_clear) else $error("bad mode acted");
  a_set_select: assert property (s_steady |-> active_set ==
    ((survey_state == 2'h1) ? 2'h1 : (survey_state == 2'h2) ? 2'h2 : 2'h0))
    else $error("active set wrong");
  a_survey_limit: assert property (take && cmd_id == `ID_CONFIG && cmd_len > `LEN_ONE
    && survey_state == 2'h1 && cmd_dyn == `DYN_STATIONARY |=> cfg_reject)
    else $error("illegal config accepted");
  a_sv_answer: assert property (sv_check |=> sv_use_valid) else $error("no verdict");
  a_land_default: assert property ($rose(nrst) |-> act_dyn == `DYN_LAND)
    else $error("dynamics default wrong");
endmodule
bind cmd_dispatch cmd_dispatch_chk i_cmd_dispatch_chk (.clk(clk), .nrst(nrst),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_id(cmd_id), .cmd_sub(cmd_sub),
  .cmd_len(cmd_len), .cmd_dyn(cmd_dyn), .survey_state(survey_state),
  .rpt_valid(rpt_valid), .rpt_ready(rpt_ready), .rpt_id(rpt_id), .rpt_sub(rpt_sub),
  .time_load(time_load), .survey_cmd(survey_cmd), .survey_arg(survey_arg),
  .mem_clear(mem_clear), .flash_clear(flash_clear), .restart(restart),
  .active_set(active_set), .act_dyn(act_dyn), .cfg_reject(cfg_reject),
  .sv_check(sv_check), .sv_use_valid(sv_use_valid));

/* File: verif/host_sink.sv */
module host_sink
  import dispatch_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] pace,
  input wire logic rpt_valid,
  output logic rpt_ready,
  input wire logic [7:0] rpt_id,
  input wire logic [7:0] rpt_sub
);
  timeunit 1ns;
  timeprecision 100ps;
  // Reports taken, in order
  rpt_t got[$];
  // Free-running phase; pace 0 prompt, 1 one cycle in four, 2 halted
  logic [1:0] phase_q;
  ////////////////////////////////////////////////////////////////////////////
  // Ready moves only on the edge
  always @(posedge clk) begin
    if (!nrst) begin
      phase_q <= 2'h0;
      rpt_ready <= 1'b0;
    end else begin
      phase_q <= phase_q + 2'h1;
      rpt_ready <= (pace == 2'h0) || (pace == 2'h1 && phase_q == 2'h3);
      if (rpt_valid && rpt_ready) begin
        got.push_back({rpt_id, rpt_sub});
      end
    end
  end
endmodule

/* File: verif/gps_packet_command_dispatch_tb.sv */
`include "dispatch_map.svh"
module gps_packet_command_dispatch_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dispatch_pkg::*;
  typedef struct {logic [7:0] id, sub, len, dyn, dim; logic [15:0] elev; logic [7:0] lvl;} pkt_s;
  logic clk = 1'b0, nrst = 1'b0, cmd_valid = 1'b0, cmd_ready, rpt_valid, rpt_ready;
  logic [7:0] cmd_id = 8'h00, cmd_sub = 8'h00, cmd_len = 8'h00, cmd_dyn = 8'h00;
  logic [7:0] cmd_dim = 8'h00, cmd_lvl = 8'h00, rpt_id, rpt_sub, survey_arg, sv_level = 8'h00;
  logic [15:0] cmd_elev = 16'h0000, sv_elev = 16'h0000, act_elev;
  logic [7:0] act_dyn, act_dim, act_lvl;
  logic [1:0] survey_state = 2'h0, active_set, pace = 2'h0;
  logic auto_en = 1'b0, fix_tick = 1'b0, sv_check = 1'b0, sv_in_use = 1'b0, sv_locked = 1'b0;
  logic survey_cmd, flash_save, mem_clear, flash_clear, restart, time_load;
  logic alt_user, cfg_written, cfg_reject, sv_use, sv_use_valid;
  int num_errors = 0, compares = 0, cycles = 0;
  pkt_s pq[$];  // Packets to offer
  rpt_t exp_q[$];  // Expected reports, in order
  always #5 clk = ~clk;
  cmd_dispatch i_cmd_dispatch (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_id(cmd_id), .cmd_sub(cmd_sub), .cmd_len(cmd_len),
    .cmd_dyn(cmd_dyn), .cmd_dim(cmd_dim), .cmd_elev(cmd_elev), .cmd_lvl(cmd_lvl),
    .rpt_valid(rpt_valid), .rpt_ready(rpt_ready), .rpt_id(rpt_id), .rpt_sub(rpt_sub),
    .auto_en(auto_en), .fix_tick(fix_tick), .survey_state(survey_state),
    .survey_cmd(survey_cmd), .survey_arg(survey_arg), .flash_save(flash_save),
    .mem_clear(mem_clear), .flash_clear(flash_clear), .restart(restart),
    .time_load(time_load), .active_set(active_set), .act_dyn(act_dyn), .act_dim(act_dim),
    .act_elev(act_elev), .act_lvl(act_lvl), .alt_user(alt_user), .cfg_written(cfg_written),
    .cfg_reject(cfg_reject), .sv_check(sv_check), .sv_elev(sv_elev), .sv_level(sv_level),
    .sv_in_use(sv_in_use), .sv_locked(sv_locked), .sv_use(sv_use), .sv_use_valid(sv_use_valid));
  host_sink i_host_sink (.clk(clk), .nrst(nrst), .pace(pace), .rpt_valid(rpt_valid),
    .rpt_ready(rpt_ready), .rpt_id(rpt_id), .rpt_sub(rpt_sub));
  ////////////////////////////////////////////////////////////////////////////
  task end_sim;
    if (num_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Queue a packet; fields default to keep
  task add(input logic [7:0] id, sub, len, dyn = `KEEP8, dim = `KEEP8,
           input logic [15:0] elev = `KEEP16, input logic [7:0] lvl = `KEEP8);
    pkt_s p;
    p = '{id, sub, len, dyn, dim, elev, lvl};
    pq.push_back(p);
  endtask
  // Queue a request and its report
  task req(input logic [7:0] id, sub, len, rid, rsub);
    add(id, sub, len);
    exp_q.push_back({rid, rsub});
  endtask
  // Offer queued packets back to back
  task send_all;
    int n;
    foreach (pq[i]) begin
      {cmd_id, cmd_sub, cmd_len} = {pq[i].id, pq[i].sub, pq[i].len};
      {cmd_dyn, cmd_dim, cmd_elev, cmd_lvl} = {pq[i].dyn, pq[i].dim, pq[i].elev, pq[i].lvl};
      cmd_valid = 1'b1;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 200) begin
        @(posedge clk);
        #1;
        n++;
      end
      check(n < 200, 1'b1);
      @(posedge clk);
      #1;
    end
    cmd_valid = 1'b0;
    pq.delete();
  endtask
  // Await reports and strays, compare in order
  task drain;
    int n;
    n = 0;
    while (i_host_sink.got.size() < exp_q.size() && n < 2000) begin
      @(posedge clk);
      n++;
    end
    repeat (20) @(posedge clk);
    #1;
    check(i_host_sink.got.size(), exp_q.size());
    foreach (exp_q[i]) if (i < i_host_sink.got.size()) check(i_host_sink.got[i], exp_q[i]);
    i_host_sink.got.delete();
    exp_q.delete();
  endtask
  // One admission query; strobe held for the next
  task sv(input logic [15:0] elev, input logic [7:0] lvl, input logic use_in, lock, exp);
    {sv_elev, sv_level, sv_in_use, sv_locked, sv_check} = {elev, lvl, use_in, lock, 1'b1};
    @(posedge clk);
    #1;
    check(sv_use_valid, 1'b1);
    check(sv_use, exp);
  endtask
  // Write a config set, check its pulse
  task cfg(input logic [7:0] dyn, dim, input logic [15:0] elev, input logic [7:0] lvl,
           input logic ok);
    add(`ID_CONFIG, `SUB_NONE, 8'h0c, dyn, dim, elev, lvl);
    send_all;
    check({cfg_written, cfg_reject}, {ok, !ok});
    repeat (3) @(posedge clk);
    #1;
  endtask
  task state(input logic [1:0] s, input logic [1:0] exp);
    survey_state = s;
    repeat (4) @(posedge clk);
    #1;
    check(active_set, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_sim;
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    #1;
    nrst = 1'b1;
    check(act_dyn, `DYN_LAND);
    check(act_elev, `ELEV_DEFAULT);
    check(act_lvl, `LVL_DEFAULT);
    check(active_set, 2'h0);
    // Every request kind but save, strays between, slow host
    pace = 2'h1;
    req(`ID_TIME_REQ, 8'h00, 8'h00, `ID_TIME_RPT, 8'h00);
    req(`ID_VER_REQ, 8'h00, 8'h00, `ID_VER_RPT, 8'h00);
    req(`ID_LEVEL_REQ, 8'h00, 8'h00, `ID_LEVEL_RPT, 8'h00);
    req(`ID_FIX_REQ, 8'h00, 8'h00, `ID_FIX_RPT, 8'h00);
    exp_q.push_back({`ID_SUPER_RPT, `SUB_EXT_FIX});
    add(8'h99, 8'h00, 8'h00);
    add(`ID_TIME_REQ, 8'h00, 8'h01);
    req(`ID_SET_TIME, 8'h00, `LEN_SET_TIME, `ID_TIME_ACK, 8'h00);
    req(`ID_SUPER, `SUB_EXT_FIX, 8'h01, `ID_SUPER_RPT, `SUB_EXT_FIX);
    req(`ID_SUPER, `SUB_SURVEY, 8'h01, `ID_SUPER_RPT, `SUB_SURVEY);
    req(`ID_CONFIG, `SUB_CFG_QUERY, 8'h01, `ID_CONFIG, 8'h00);
    add(`ID_CLEAR_RST, 8'h00, 8'h01);
    send_all;
    drain;
    // Host halted: queue fills, port refuses, then drains
    pace = 2'h2;
    for (int i = 0; i < 34; i++) req(`ID_VER_REQ, 8'h00, 8'h00, `ID_VER_RPT, 8'h00);
    fork
      send_all;
      begin
        repeat (70) @(posedge clk);
        #1;
        check(cmd_ready, 1'b0);
        pace = 2'h0;
      end
    join
    drain;
    // Automatic fix report only while enabled
    auto_en = 1'b1;
    fix_tick = 1'b1;
    exp_q.push_back({`ID_SUPER_RPT, `SUB_EXT_FIX});
    @(posedge clk);
    #1;
    {auto_en, fix_tick} = 2'b01;
    @(posedge clk);
    #1;
    fix_tick = 1'b0;
    drain;
    // Both clear modes, only here
    add(`ID_CLEAR_RST, `MODE_COLD, 8'h01);
    add(`ID_CLEAR_RST, `MODE_FACTORY, 8'h01);
    send_all;
    drain;
    // Mobile set: anything goes, keep codes hold
    cfg(`DYN_SEA, `DIM_AUTO, `KEEP16, 8'h20, 1'b1);
    check(act_dyn, `DYN_SEA);
    check(act_elev, `ELEV_DEFAULT);
    check(act_lvl, 8'h20);
    check(alt_user, 1'b1);
    sv(16'h06d0, 8'h40, 1'b0, 1'b0, 1'b0);
    sv(16'h06d1, 8'h22, 1'b0, 1'b0, 1'b1);
    sv(16'h06d1, 8'h21, 1'b0, 1'b0, 1'b0);
    sv(16'h06d1, 8'h1e, 1'b1, 1'b1, 1'b1);
    sv(16'h06d1, 8'h1d, 1'b1, 1'b1, 1'b0);
    sv(16'h06d1, 8'h1e, 1'b1, 1'b0, 1'b0);
    sv_check = 1'b0;
    // Survey set: state first, then config, then save
    state(2'h1, 2'h1);
    check(act_dyn, `DYN_LAND);
    cfg(`DYN_STATIONARY, `DIM_3D, `KEEP16, `KEEP8, 1'b0);
    check(act_dyn, `DYN_LAND);
    cfg(`DYN_AIR, `DIM_3D, `KEEP16, `KEEP8, 1'b1);
    check(act_dyn, `DYN_AIR);
    req(`ID_SUPER, `SUB_SAVE, 8'h01, `ID_SUPER_RPT, `SUB_SAVE);
    send_all;
    check(flash_save, 1'b1);
    drain;
    // Timing set: stationary, timing dimension
    state(2'h2, 2'h2);
    cfg(`DYN_STATIONARY, `DIM_OVERDET, `KEEP16, `KEEP8, 1'b1);
    check(act_dim, `DIM_OVERDET);
    // Back to mobile: edits survived
    state(2'h0, 2'h0);
    check(act_dyn, `DYN_SEA);
    end_sim;
  end
endmodule
